// ---- src/bst_pkg.sv ----
// constants for the boundary-scan test access port
// assumes the system clock runs well above the sampled test clock
package bst_pkg;
  localparam int          IR_W        = 4;
  localparam int          ID_W        = 32;
  localparam int          NPINS       = 8;
  localparam int          BSR_W       = 3 * NPINS;
  localparam logic [3:0]  IR_EXTEST   = 4'h0;
  localparam logic [3:0]  IR_CLAMP    = 4'h2;
  localparam logic [3:0]  IR_HIGHZ    = 4'h3;
  localparam logic [3:0]  IR_SAMPLE   = 4'h4;
  localparam logic [3:0]  IR_IDCODE   = 4'hE;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [1:0]  IR_CAPTURE  = 2'h1;
  // identification code: arbitrary neutral value, bit 0 forced to one
  localparam logic [31:0] ID_CODE     = 32'h1000_0001;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_type;
endpackage

// ---- src/bst_tap.sv ----
// boundary-scan test access port with a small boundary chain
// assumes test pins arrive asynchronously and are sampled by sys_clk_i
`timescale 1ns/1ns
module bst_tap
(
  // system
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       clk_en_i,
  // test pins
  input  wire logic                       test_clock_pin_i,
  input  wire logic                       test_mode_select_i,
  input  wire logic                       test_serial_in_i,
  input  wire logic                       test_reset_n_i,
  output logic                            test_serial_out_o,
  output logic                            test_serial_out_oe_o,
  // core side of the scanned pins
  input  wire logic [bst_pkg::NPINS-1:0]  core_out_i,
  input  wire logic [bst_pkg::NPINS-1:0]  core_oe_i,
  output logic      [bst_pkg::NPINS-1:0]  core_in_o,
  // pad side of the scanned pins
  input  wire logic [bst_pkg::NPINS-1:0]  pad_in_i,
  output logic      [bst_pkg::NPINS-1:0]  pad_out_o,
  output logic      [bst_pkg::NPINS-1:0]  pad_oe_o,
  // status
  output logic      [bst_pkg::IR_W-1:0]   instr_o
);
  // two-stage synchronisers, reset to the pins' idle high level
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic       tck_d_r;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_r    <= 4'hF;
      s2_r    <= 4'hF;
      tck_d_r <= 1'b1;
    end
    else if (clk_en_i)
    begin
      s1_r    <= {test_reset_n_i, test_clock_pin_i, test_mode_select_i, test_serial_in_i};
      s2_r    <= s1_r;
      tck_d_r <= s2_r[2];
    end
  wire trst_n = s2_r[3];
  wire tms    = s2_r[1];
  wire tdi    = s2_r[0];
  wire rise   = clk_en_i && s2_r[2] && !tck_d_r;
  wire fall   = clk_en_i && !s2_r[2] && tck_d_r;
  // test reset low masks every test clock edge
  wire trst_act = clk_en_i && !trst_n;
  wire step     = rise && trst_n;
  wire drop     = fall && trst_n;

  bst_pkg::bst_state_type st_r;
  bst_pkg::bst_state_type st_nxt;
  always_comb
  begin
    unique case (st_r)
      bst_pkg::ST_RESET:  st_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE:   st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: st_nxt = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: st_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR:  st_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: st_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: st_nxt = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: st_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: st_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: st_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR:  st_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: st_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: st_nxt = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: st_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
    endcase
  end

  // instruction decode
  logic [3:0]              ir_r;
  logic [3:0]              ir_sh_r;
  logic [31:0]             dr_sh_r;
  logic [bst_pkg::BSR_W-1:0] bsr_sh_r;
  logic [bst_pkg::BSR_W-1:0] bsr_up_r;
  logic                    tdo_r;
  logic                    tdo_en_r;
  wire is_ext  = ir_r == bst_pkg::IR_EXTEST;
  wire is_clmp = ir_r == bst_pkg::IR_CLAMP;
  wire is_hz   = ir_r == bst_pkg::IR_HIGHZ;
  wire is_smp  = ir_r == bst_pkg::IR_SAMPLE;
  wire is_id   = ir_r == bst_pkg::IR_IDCODE;
  // highz and unknown codes use bypass
  wire sel_bsr = is_ext || is_smp;
  wire sel_id  = is_id;
  // chain frozen under clamp and highz
  wire bsr_act = sel_bsr;
  wire       in_sh_dr = st_r == bst_pkg::ST_SH_DR;
  wire       in_sh_ir = st_r == bst_pkg::ST_SH_IR;
  wire       cap_dr   = st_r == bst_pkg::ST_CAP_DR;
  wire       upd_dr   = st_r == bst_pkg::ST_UPD_DR;
  wire       cap_ir   = st_r == bst_pkg::ST_CAP_IR;
  wire       upd_ir   = st_r == bst_pkg::ST_UPD_IR;
  wire       go_reset = st_nxt == bst_pkg::ST_RESET;

  // captured pin snapshot: per pin input, enable, output cells
  logic [bst_pkg::BSR_W-1:0] snap;
  // only general pins are in the chain
  for (genvar g = 0; g < bst_pkg::NPINS; g++)
  begin : g_cell
    assign snap[3*g+2] = pad_in_i[g];
    // enable cell takes core_oe_i as it stands
    assign snap[3*g+1] = core_oe_i[g];
    assign snap[3*g]   = core_out_i[g];
  end

  // only extest and clamp hand the pins to the chain
  wire drive_bsr = is_ext || is_clmp;
  assign core_in_o = pad_in_i;
  // pin muxing, one slice per scanned pin
  for (genvar k = 0; k < bst_pkg::NPINS; k++)
  begin : g_pin
    wire out_sel = drive_bsr ? bsr_up_r[3*k]   : core_out_i[k];
    wire oe_sel  = drive_bsr ? bsr_up_r[3*k+1] : core_oe_i[k];
    assign pad_out_o[k] = out_sel;
    assign pad_oe_o[k]  = oe_sel && !is_hz;
  end

  // data register next values
  wire [31:0] dr_cap   = sel_id ? bst_pkg::ID_CODE : 32'h0000_0000;
  // serial in enters at the top of the selected length
  wire [31:0] dr_shift = sel_id ? {tdi, dr_sh_r[31:1]} : {31'h0, tdi};
  wire        out_bit  = in_sh_ir ? ir_sh_r[0] : (sel_bsr ? bsr_sh_r[0] : dr_sh_r[0]);

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      st_r <= bst_pkg::ST_RESET;
    else if (trst_act)
      st_r <= bst_pkg::ST_RESET;
    else if (step)
      st_r <= st_nxt;

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      ir_r <= bst_pkg::IR_IDCODE;
    else if (trst_act)
      ir_r <= bst_pkg::IR_IDCODE;
    else if (step && go_reset)
      ir_r <= bst_pkg::IR_IDCODE;
    else if (step && upd_ir)
      ir_r <= ir_sh_r;

  // lsb first into the instruction shifter
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      ir_sh_r <= 4'h0;
    else if (step && cap_ir)
      ir_sh_r <= {2'b00, bst_pkg::IR_CAPTURE};
    else if (step && in_sh_ir)
      ir_sh_r <= {tdi, ir_sh_r[3:1]};

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      dr_sh_r <= 32'h0000_0000;
    else if (step && cap_dr)
      dr_sh_r <= dr_cap;
    else if (step && in_sh_dr)
      dr_sh_r <= dr_shift;

  // chain moves only under sample and extest
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      bsr_sh_r <= '0;
    else if (step && cap_dr && bsr_act)
      bsr_sh_r <= snap;
    else if (step && in_sh_dr && bsr_act)
      bsr_sh_r <= {tdi, bsr_sh_r[bst_pkg::BSR_W-1:1]};

  // update latch drives the pins under extest and clamp
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      bsr_up_r <= '0;
    else if (step && upd_dr && bsr_act)
      bsr_up_r <= bsr_sh_r;

  // serial out lsb first, changes on falling edge
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      tdo_r <= 1'b0;
    else if (drop && (in_sh_ir || in_sh_dr))
      tdo_r <= out_bit;

  // serial out enabled only in the shift states
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      tdo_en_r <= 1'b0;
    else if (trst_act)
      tdo_en_r <= 1'b0;
    else if (drop)
      tdo_en_r <= in_sh_dr || in_sh_ir;

  assign test_serial_out_o    = tdo_r;
  assign test_serial_out_oe_o = tdo_en_r;
  assign instr_o              = ir_r;
endmodule

// ---- dv/bst_tap_props.sv ----
// pin-level assertions for the test access port
// assumes it is bound into bst_tap and samples on the system clock
`timescale 1ns/1ns
module bst_tap_props
(
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  // test pins
  input wire logic       test_clock_pin_i,
  input wire logic       test_reset_n_i,
  input wire logic       test_serial_out_o,
  input wire logic       test_serial_out_oe_o,
  // scanned pins
  input wire logic [7:0] core_out_i,
  input wire logic [7:0] core_oe_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  // status
  input wire logic [3:0] instr_o
);
  wire pins_normal = pad_oe_o == core_oe_i && pad_out_o == core_out_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_highz_float: assert property (instr_o == 4'h3 |-> pad_oe_o == 8'h00)
    else $error("pins driven under highz");
  a_idcode_pins: assert property (instr_o == 4'hE |-> pins_normal)
    else $error("pins disturbed under idcode");
  a_spare_pins: assert property (instr_o inside {4'h1, [4'h5:4'hD]} |-> pins_normal)
    else $error("pins disturbed under spare code");
  a_clamp_frozen: assert property (
    instr_o == 4'h2 && $past(instr_o) == 4'h2 |-> $stable({pad_oe_o, pad_out_o}))
    else $error("clamped pins moved");
  a_rst_idcode: assert property ($fell(rst_i) |-> instr_o == 4'hE)
    else $error("no idcode after reset");
  a_trst_idcode: assert property ($fell(test_reset_n_i) |-> ##[1:6] instr_o == 4'hE)
    else $error("test reset did not select idcode");
  a_trst_held: assert property (!test_reset_n_i [*6] |-> instr_o == 4'hE)
    else $error("instruction moved in test reset");
  a_trst_quiet: assert property (!test_reset_n_i [*6] |-> !test_serial_out_oe_o)
    else $error("serial out driven in test reset");
  a_out_on_fall: assert property (
    test_reset_n_i && $changed(test_serial_out_o) |-> !test_clock_pin_i)
    else $error("serial out moved with test clock high");
endmodule
bind bst_tap bst_tap_props bst_tap_props_inst (.sys_clk_i, .rst_i, .test_clock_pin_i,
  .test_reset_n_i, .test_serial_out_o, .test_serial_out_oe_o, .core_out_i, .core_oe_i,
  .pad_out_o, .pad_oe_o, .instr_o);

// ---- dv/bst_tester.sv ----
// board tester model driving the test pins
// assumes serial out settles within half a test clock
`timescale 1ns/1ns
module bst_tester
(
  // clock, mode select and serial in rest high until the port is used; test reset rests low
  output logic      tck_o = 1'b1, tms_o = 1'b1, tdi_o = 1'b1,
  output logic      trst_n_o = 1'b0,
  input  wire logic tdo_i
);
  // one 125 ns test clock, serial out taken at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    {tms_o, tdi_o} = {tms, tdi};
    #62 tck_o = 1'b1;
    tdo = tdo_i;
    #63 tck_o = 1'b0;
  endtask
  // reset low for twenty test clocks, then raised
  task automatic port_reset();
    logic d;
    trst_n_o = 1'b0;
    repeat (20) tick(1'b1, 1'b1, d);
    trst_n_o = 1'b1;
  endtask
endmodule

// ---- dv/bst_tap_bench.sv ----
// bench for the test access port: code table, then awkward cases
// assumes the tester model owns every test pin
`timescale 1ns/1ns
module bst_tap_bench;
  typedef struct { logic [3:0] code; int len; int pins; } bst_row_type;
  localparam logic [63:0] DIN = 64'hC3A5_96F0_0F69_5A3C;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0]  c_out = 8'hA5, c_oe = 8'h3C, p_in = 8'h96, c_in, p_out, p_oe;
  logic [3:0]  instr;
  logic [63:0] dout;
  logic [7:0]  exp_out, exp_oe;
  logic [23:0] exp_snap;
  int          mismatches = 0, n_tests = 0, cycles = 0;
  bst_row_type rows [7] = '{'{4'hF, 1, 0}, '{4'h4, 24, 0}, '{4'h3, 1, 1}, '{4'h2, 1, 2},
    '{4'h0, 24, 2}, '{4'h7, 1, 0}, '{4'hE, 32, 0}};
  always #5 sys_clk_i = ~sys_clk_i;
  bst_tap bst_tap_inst (.sys_clk_i, .rst_i, .clk_en_i(1'b1), .test_clock_pin_i(tck),
    .test_mode_select_i(tms), .test_serial_in_i(tdi), .test_reset_n_i(trst_n),
    .test_serial_out_o(tdo), .test_serial_out_oe_o(tdo_oe), .core_out_i(c_out),
    .core_oe_i(c_oe), .core_in_o(c_in), .pad_in_i(p_in), .pad_out_o(p_out),
    .pad_oe_o(p_oe), .instr_o(instr));
  bst_tester bst_tester_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo));
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    mismatches += int'(seen !== exp);
    if (seen !== exp) $display("mismatch %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic final_report(input int hung);
    mismatches += hung;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // from idle or reset into a shift state, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din);
    logic d;
    for (int i = 0; i < (ir ? 5 : 4); i++) bst_tester_inst.tick(i == 1 || (ir && i == 2), 1'b0, d);
    for (int i = 0; i < n; i++) bst_tester_inst.tick(i == n - 1, din[i], dout[i]);
    bst_tester_inst.tick(1'b1, 1'b0, d);
    bst_tester_inst.tick(1'b0, 1'b0, d);
  endtask
  always @(posedge sys_clk_i) if (++cycles == 15000) final_report(1);
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    // chain image: pin k out at 3k, enable at 3k+1, input at 3k+2; preload is DIN[31:8]
    for (int k = 0; k < 8; k++)
    begin
      {exp_oe[k], exp_out[k]} = {DIN[3*k+9], DIN[3*k+8]};
      exp_snap[3*k +: 3] = {p_in[k], c_oe[k], c_out[k]};
    end
    bst_tester_inst.port_reset();
    check("reset instr", instr, 4'hE);
    foreach (rows[r])
    begin
      scan(1'b1, 4, rows[r].code);
      check("ir capture", dout[3:0], 4'h1);
      check("instr", instr, rows[r].code);
      if (rows[r].pins == 0) check("pins", {p_oe, p_out, c_in}, {c_oe, c_out, p_in});
      if (rows[r].pins == 1) check("float", p_oe, 8'h00);
      if (rows[r].pins == 2) check("driven", {p_oe, p_out}, {exp_oe, exp_out});
      scan(1'b0, rows[r].len + 8, DIN);
      check("echo", dout[rows[r].len +: 8], DIN[7:0]);
      if (rows[r].len == 24) check("capture", dout[23:0], exp_snap);
      if (rows[r].len == 1) check("bypass", dout[0], 1'b0);
      if (rows[r].len == 32) check("id", dout[31:0], bst_pkg::ID_CODE);
    end
    scan(1'b1, 4, 4'hF);
    repeat (5) bst_tester_inst.tick(1'b1, 1'b0, dout[0]);
    check("mode reset", instr, 4'hE);
    scan(1'b1, 4, 4'hF);
    for (int i = 0; i < 7; i++) bst_tester_inst.tick(i == 1, 1'b1, dout[i]);
    check("oe shift", tdo_oe, 1'b1);
    bst_tester_inst.port_reset();
    check("oe reset", tdo_oe, 1'b0);
    check("broken shift", instr, 4'hE);
    scan(1'b0, 32, DIN);
    check("id retry", dout[31:0], bst_pkg::ID_CODE);
    final_report(0);
  end
endmodule
